// ===== hdl/tpp_params.svh
`ifndef TPP_PARAMS_SVH
`define TPP_PARAMS_SVH
// Function
// [RL1] periodic mode output has exactly fifty percent duty
// [RL2] periodic frequency is source / (2 x (bound+1) x prescale x (scaler+1))
// [RL3] scale bits 6:5 pick prescale 1, 4, 16 or 64
// [RL4] scale bits 4:0 divide the prescaled clock by value plus one
// [RL5] bound register holds the count limit: period or duty
// [RL6] control bits 7:4 pick the clock source
// [RL7] control bit 1 set, scale bit 7 clear: 8-bit pwm
// [RL8] 8-bit pwm frequency is source / (256 x prescale x (scaler+1))
// [RL9] 8-bit pwm high for bound+1 of 256 ticks
// [RL10] control bit 1 set, scale bit 7 set: 6-bit pwm
// [RL11] 6-bit pwm frequency is source / (64 x prescale x (scaler+1))
// [RL12] 6-bit pwm high for bound+1 of 64 ticks
// [RL13] source 0001, select 10, mode set: system clock, first pin, pwm
// [RL14] counter counts up only and wraps to zero at the bound
// [RL15] count register writes load the counter, reads return it
// [RL16] control bits 3:2 route the wave to one of three pins
// [RL17] periodic wave toggles on each wrap; wrap raises an interrupt

// ------------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------------
`define TPP_OFF_CTRL  6'h00
`define TPP_OFF_BOUND 6'h04
`define TPP_OFF_SCALE 6'h08
`define TPP_OFF_COUNT 6'h0C
`define TPP_OFF_STAT  6'h10
`define TPP_OFF_MASK  6'h14

// ------------------------------------------------------------------
// fields, codes and constants
// ------------------------------------------------------------------
`define TPP_CTRL_SRC  7:4
`define TPP_CTRL_SEL  3:2
`define TPP_CTRL_PWM  1
`define TPP_SCALE_RES 7
`define TPP_SCALE_PRE 6:5
`define TPP_SCALE_DIV 4:0
`define TPP_SRC_OFF   4'h0
`define TPP_SRC_SYS   4'h1
`define TPP_SRC_EXT0  4'h2
`define TPP_SRC_EXTN  4'h8
`define TPP_PRE_M1    6'h00
`define TPP_PRE_M4    6'h03
`define TPP_PRE_M16   6'h0F
`define TPP_PRE_M64   6'h3F
`define TPP_SEL_PIN0  2'h2
`define TPP_SEL_PIN1  2'h3
`define TPP_SEL_PIN2  2'h1
`define TPP_TOP8      8'hFF
`define TPP_TOP6      8'h3F
`define TPP_RESP_OK   2'h0
`define TPP_RESP_ERR  2'h2
`define TPP_ZERO8     8'h00
`endif

// ===== hdl/tpp_pkg.sv
package tpp_pkg;

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TPP_PERIOD,
        TPP_PWM8,
        TPP_PWM6
    } tpp_mode_e;

    // ------------------------------------------------------------------
    // whole state of the timer block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] bound;
        logic [7:0] scale;
        logic [7:0] count;
        logic       status;
        logic       mask;
        logic [7:0] src_prev;
        logic [5:0] pre_cnt;
        logic [4:0] scl_cnt;
        logic       wave;
        logic [2:0] pins;
        logic       irq;
        logic       awready;
        logic       wready;
        logic       aw_got;
        logic       w_got;
        logic [5:0] aw_addr;
        logic [7:0] w_data;
        logic       w_lane0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } tpp_state_s;

endpackage

// ===== hdl/tpp_timer.sv
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tpp_params.svh"

module tpp_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  src_in,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [2:0]       timer_pin,
    output logic             irq
);

    // ------------------------------------------------------------------
    // state and working signals
    // ------------------------------------------------------------------
    tpp_pkg::tpp_state_s st;
    tpp_pkg::tpp_state_s next_st;
    tpp_pkg::tpp_mode_e  mode;
    logic                aw_take;
    logic                w_take;
    logic                ar_take;
    logic                load;
    logic                src_tick;
    logic                pre_hit;
    logic                tick;
    logic                wrap;
    logic [5:0]          pre_mask;
    logic [7:0]          top;
    logic [3:0]          ext_idx;
    logic [7:0]          src_edge;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st  = st;
        aw_take  = s_axi_awvalid & st.awready;
        w_take   = s_axi_wvalid & st.wready;
        ar_take  = s_axi_arvalid & st.arready;
        load     = 1'b0;
        src_tick = 1'b0;
        pre_hit  = 1'b0;
        tick     = 1'b0;
        wrap     = 1'b0;
        pre_mask = `TPP_PRE_M1;
        top      = `TPP_TOP8;
        ext_idx  = 4'h0;
        mode     = tpp_pkg::TPP_PERIOD;
        src_edge = src_in & ~st.src_prev;

        // address and data may arrive in either order
        if (aw_take) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr[5:0];
        end
        if (w_take) begin
            next_st.w_got   = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // register write once both halves are held
        if (next_st.aw_got && next_st.w_got && !next_st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `TPP_RESP_OK;
            case (next_st.aw_addr)
                `TPP_OFF_CTRL: begin
                    if (next_st.w_lane0) next_st.ctrl = next_st.w_data;
                end
                `TPP_OFF_BOUND: begin
                    if (next_st.w_lane0) next_st.bound = next_st.w_data; // [RL5]
                end
                `TPP_OFF_SCALE: begin
                    if (next_st.w_lane0) next_st.scale = next_st.w_data;
                end
                `TPP_OFF_COUNT: begin
                    load = next_st.w_lane0; // [RL15]
                end
                `TPP_OFF_STAT: begin
                    // write one to clear; a same-cycle wrap sets it again below
                    if (next_st.w_lane0 && next_st.w_data[0]) next_st.status = 1'b0;
                end
                `TPP_OFF_MASK: begin
                    if (next_st.w_lane0) next_st.mask = next_st.w_data[0];
                end
                default: begin
                    next_st.bresp = `TPP_RESP_ERR;
                end
            endcase
        end

        // register read, answered one cycle after the address is taken
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `TPP_RESP_OK;
            case (s_axi_araddr[5:0])
                `TPP_OFF_CTRL:  next_st.rdata = st.ctrl;
                `TPP_OFF_BOUND: next_st.rdata = st.bound;
                `TPP_OFF_SCALE: next_st.rdata = st.scale;
                `TPP_OFF_COUNT: next_st.rdata = st.count; // [RL15]
                `TPP_OFF_STAT:  next_st.rdata = {7'h00, st.status};
                `TPP_OFF_MASK:  next_st.rdata = {7'h00, st.mask};
                default: begin
                    next_st.rdata = `TPP_ZERO8;
                    next_st.rresp = `TPP_RESP_ERR;
                end
            endcase
        end

        // mode decode from control and scale
        if (!next_st.ctrl[`TPP_CTRL_PWM]) begin
            mode = tpp_pkg::TPP_PERIOD;
        end else if (next_st.scale[`TPP_SCALE_RES]) begin
            mode = tpp_pkg::TPP_PWM6; // [RL10]
        end else begin
            mode = tpp_pkg::TPP_PWM8; // [RL7]
        end

        // clock source select; external sources count rising edges
        next_st.src_prev = src_in;
        ext_idx = next_st.ctrl[`TPP_CTRL_SRC] - `TPP_SRC_EXT0;
        case (next_st.ctrl[`TPP_CTRL_SRC]) // [RL6]
            `TPP_SRC_OFF: src_tick = 1'b0;
            `TPP_SRC_SYS: src_tick = 1'b1; // [RL13]
            default: begin
                if (ext_idx < `TPP_SRC_EXTN) src_tick = src_edge[ext_idx[2:0]];
            end
        endcase

        // prescaler: free-running count, hit when low bits all ones
        case (next_st.scale[`TPP_SCALE_PRE]) // [RL3]
            2'h0:    pre_mask = `TPP_PRE_M1;
            2'h1:    pre_mask = `TPP_PRE_M4;
            2'h2:    pre_mask = `TPP_PRE_M16;
            default: pre_mask = `TPP_PRE_M64;
        endcase
        if (src_tick) begin
            next_st.pre_cnt = st.pre_cnt + 6'h01;
            pre_hit = ((st.pre_cnt & pre_mask) == pre_mask);
        end

        // scaler: >= so a lowered divider never waits a whole wrap
        if (pre_hit) begin
            tick = (st.scl_cnt >= next_st.scale[`TPP_SCALE_DIV]); // [RL4]
            next_st.scl_cnt = tick ? 5'h00 : st.scl_cnt + 5'h01;
        end

        // counter limit depends on mode
        case (mode)
            tpp_pkg::TPP_PERIOD: top = next_st.bound; // [RL2] [RL5]
            tpp_pkg::TPP_PWM8:   top = `TPP_TOP8;     // [RL8]
            tpp_pkg::TPP_PWM6:   top = `TPP_TOP6;     // [RL11]
            default:             top = `TPP_TOP8;
        endcase

        // up counter; a software load beats the tick
        wrap = tick && !load && (st.count >= top);
        if (load) begin
            next_st.count = next_st.w_data;
        end else if (tick) begin
            next_st.count = wrap ? `TPP_ZERO8 : st.count + 8'h01; // [RL14]
        end

        // waveform
        if (mode == tpp_pkg::TPP_PERIOD) begin
            if (wrap) next_st.wave = ~st.wave; // [RL1] [RL17]
        end else begin
            next_st.wave = (next_st.count <= next_st.bound); // [RL9] [RL12]
        end

        // sticky interrupt, set wins over clear
        if (wrap) next_st.status = 1'b1; // [RL17]

        // pin routing
        next_st.pins = 3'h0;
        case (next_st.ctrl[`TPP_CTRL_SEL]) // [RL16]
            `TPP_SEL_PIN0: next_st.pins[0] = next_st.wave; // [RL13]
            `TPP_SEL_PIN1: next_st.pins[1] = next_st.wave;
            `TPP_SEL_PIN2: next_st.pins[2] = next_st.wave;
            default:       next_st.pins = 3'h0;
        endcase

        next_st.irq     = next_st.status & next_st.mask;
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    // ------------------------------------------------------------------
    // state register; ce low freezes everything, bus included
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = {24'h000000, st.rdata};
    assign timer_pin     = st.pins;
    assign irq           = st.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic pwm8_now;
    logic pwm6_now;
    logic period_now;
    assign pwm8_now   = st.ctrl[`TPP_CTRL_PWM] && !st.scale[`TPP_SCALE_RES];
    assign pwm6_now   = st.ctrl[`TPP_CTRL_PWM] && st.scale[`TPP_SCALE_RES];
    assign period_now = !st.ctrl[`TPP_CTRL_PWM];

    // periodic wave flips on every wrap at the bound
    AST_PERIOD_TOGGLE: assert property ( // [RL1]
        ce && wrap && mode == tpp_pkg::TPP_PERIOD |=> st.wave != $past(st.wave)
    ) else $error("periodic wave did not toggle at wrap");

    // counter returns to zero after reaching the bound
    AST_WRAP_ZERO: assert property ( // [RL14]
        ce && tick && !load && period_now && st.count == st.bound
        && next_st.ctrl == st.ctrl && next_st.bound == st.bound
        |=> st.count == 8'h00
    ) else $error("counter did not wrap at bound");

    // 8-bit pwm wraps after 255, independent of bound
    AST_PWM8_WRAP: assert property ( // [RL8]
        ce && tick && !load && mode == tpp_pkg::TPP_PWM8 && st.count == 8'hFF
        |=> st.count == 8'h00
    ) else $error("8-bit pwm counter did not wrap at 255");

    // 6-bit pwm wraps after 63
    AST_PWM6_WRAP: assert property ( // [RL11]
        ce && tick && !load && mode == tpp_pkg::TPP_PWM6 && st.count == 8'h3F
        |=> st.count == 8'h00
    ) else $error("6-bit pwm counter did not wrap at 63");

    // pwm level follows count against bound
    AST_PWM8_LEVEL: assert property ( // [RL9]
        pwm8_now |-> st.wave == (st.count <= st.bound)
    ) else $error("8-bit pwm level wrong");

    AST_PWM6_LEVEL: assert property ( // [RL12]
        pwm6_now && st.bound == 8'h3F && st.count <= 8'h3F |-> st.wave
    ) else $error("6-bit pwm full duty not high");

    // a tick never comes without a prescaler hit at scaler end
    AST_TICK_CAUSE: assert property ( // [RL4]
        tick |-> pre_hit && st.scl_cnt >= next_st.scale[`TPP_SCALE_DIV]
    ) else $error("tick without scaler terminal count");

    // prescale 4: a hit only every fourth source tick
    AST_PRE_FOUR: assert property ( // [RL3]
        pre_hit && next_st.scale[`TPP_SCALE_PRE] == 2'h1 |-> st.pre_cnt[1:0] == 2'h3
    ) else $error("prescale by four mis-timed");

    // count writes load the counter
    AST_LOAD: assert property ( // [RL15]
        ce && load |=> st.count == $past(next_st.w_data)
    ) else $error("count write did not load counter");

    // selected pin carries the wave
    AST_PIN_SEL: assert property ( // [RL16]
        st.ctrl[`TPP_CTRL_SEL] == `TPP_SEL_PIN0 |-> timer_pin == {2'h0, st.wave}
    ) else $error("wave not on first pin");

    // the second code drives only the middle pin
    AST_PIN1_SEL: assert property ( // [RL16]
        st.ctrl[`TPP_CTRL_SEL] == `TPP_SEL_PIN1 |-> timer_pin == {1'b0, st.wave, 1'b0}
    ) else $error("wave not on second pin");

    // the third code drives only the top pin
    AST_PIN2_SEL: assert property ( // [RL16]
        st.ctrl[`TPP_CTRL_SEL] == `TPP_SEL_PIN2 |-> timer_pin == {st.wave, 2'h0}
    ) else $error("wave not on third pin");

    // spare code leaves every pin low
    AST_PIN_NONE: assert property ( // [RL16]
        st.ctrl[`TPP_CTRL_SEL] == 2'h0 |-> timer_pin == 3'h0
    ) else $error("pin driven with no pin selected");

    // ce low holds every state bit, bus included
    AST_CE_FREEZE: assert property (
        !ce |=> $stable(st)
    ) else $error("state moved while clock enable low");

    // read answered one cycle after the address is taken
    AST_RRESP: assert property (
        ce && ar_take |=> s_axi_rvalid
    ) else $error("read response late");

    // wrap raises the sticky status next cycle
    AST_IRQ_SET: assert property ( // [RL17]
        ce && wrap |=> st.status ##0 (irq == st.mask)
    ) else $error("wrap did not set interrupt status");

    // write answered one cycle after both halves arrive
    AST_BRESP: assert property (
        ce && aw_take && w_take && !st.bvalid |=> s_axi_bvalid
    ) else $error("write response late");

    COV_PERIOD_WRAP: cover property (ce && wrap && period_now);
    COV_PWM8_WRAP: cover property (ce && wrap && pwm8_now);
    COV_PWM6_WRAP: cover property (ce && wrap && pwm6_now);
    COV_IRQ: cover property (irq ##1 !irq);
    COV_EXT_TICK: cover property (ce && src_tick && next_st.ctrl[`TPP_CTRL_SRC] != `TPP_SRC_SYS);

endmodule

// ===== sim/timer8_period_pwm_tb.sv
`timescale 1ns/1ps
`include "tpp_params.svh"

module timer8_period_pwm_tb;
    // ------------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------------
    logic        aclk;
    logic        aresetn;
    logic        ce;
    logic [7:0]  src_in;
    logic [31:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [2:0]  timer_pin;
    logic        irq;
    int          bad_count;
    int          total_checks;
    int          cycles = 0;
    localparam logic [31:0] A_CTRL  = {26'h0000000, `TPP_OFF_CTRL};
    localparam logic [31:0] A_BOUND = {26'h0000000, `TPP_OFF_BOUND};
    localparam logic [31:0] A_SCALE = {26'h0000000, `TPP_OFF_SCALE};
    localparam logic [31:0] A_COUNT = {26'h0000000, `TPP_OFF_COUNT};
    localparam logic [31:0] A_STAT  = {26'h0000000, `TPP_OFF_STAT};
    localparam logic [31:0] A_MASK  = {26'h0000000, `TPP_OFF_MASK};

    tpp_timer uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .src_in(src_in),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .timer_pin(timer_pin), .irq(irq));

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    // 25 ns period
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // longest scenario is a few thousand cycles; ceiling leaves ample margin
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // sample just after an edge, where registered outputs have settled
    task automatic smp();
        @(posedge aclk);
        #1;
    endtask

    // readies are taken one ns after an edge, so they hold at the next edge
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic       ar;
        logic       wr;
        logic       bv;
        logic [1:0] br;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            #1;
            ar = s_axi_awready;
            wr = s_axi_wready;
            bv = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge aclk);
            if (ar && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (wr && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (bv && s_axi_bready) begin
                resp = br;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar;
        logic rv;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            #1;
            ar = s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (rv && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("bresp", {30'h00000000, r}, 32'h00000000);
    endtask

    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        chk("rresp", {30'h00000000, r}, 32'h00000000);
        chk(name, d, exp);
    endtask

    // high time and whole period of one pin, in clock cycles, from a rising edge
    task automatic meas(input int b, output int hi, output int per);
        hi = 0;
        while (timer_pin[b] !== 1'b0) smp();
        while (timer_pin[b] !== 1'b1) smp();
        while (timer_pin[b] === 1'b1) begin
            hi++;
            smp();
        end
        per = hi;
        while (timer_pin[b] === 1'b0) begin
            per++;
            smp();
        end
    endtask

    // ------------------------------------------------------------------
    // stimulus and checks
    // ------------------------------------------------------------------
    initial begin
        int          hi;
        int          per;
        int          lows;
        logic [2:0]  seen;
        logic [31:0] d;
        logic [1:0]  r;
        int          pb[5] = '{1, 1, 1, 1, 3};
        logic [7:0]  ps[5] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'h00};
        int          ph[5] = '{4, 16, 64, 256, 4};
        logic [7:0]  ws[4] = '{8'h00, 8'h01, 8'h80, 8'hA0};
        logic [7:0]  wb[4] = '{8'h09, 8'h7F, 8'h00, 8'h1F};
        int          wh[4] = '{10, 256, 1, 128};
        int          wp[4] = '{256, 512, 64, 256};
        logic [1:0]  sel[4] = '{2'h2, 2'h3, 2'h1, 2'h0};
        logic [2:0]  pin[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        {aresetn, ce, src_in, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
        {s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready, bad_count, total_checks} = '0;
        ce = 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // every register starts at zero, unmapped places answer with an error
        for (int i = 0; i < 6; i++) rdc("reset value", i * 4, 32'h00000000);
        axr(32'h00000018, d, r);
        chk("unmapped rresp", {30'h00000000, r}, 32'h00000002);
        chk("unmapped rdata", d, 32'h00000000);
        axw(32'h0000001C, 32'h000000FF, r);
        chk("unmapped bresp", {30'h00000000, r}, 32'h00000002);
        // register access with the source off, upper bits dropped
        wr(A_BOUND, 32'hFFFFFF5A);
        rdc("bound", A_BOUND, 32'h0000005A);
        wr(A_SCALE, 32'h000000E7);
        rdc("scale", A_SCALE, 32'h000000E7);
        wr(A_CTRL, 32'h0000000E);
        rdc("ctrl", A_CTRL, 32'h0000000E);
        wr(A_COUNT, 32'h123456A5);
        rdc("count load", A_COUNT, 32'h000000A5);
        // periodic wave across all prescale codes; second period is the settled one
        wr(A_CTRL, 32'h00000018);
        for (int i = 0; i < 5; i++) begin
            wr(A_BOUND, pb[i]);
            wr(A_SCALE, {24'h000000, ps[i]});
            meas(0, hi, per);
            meas(0, hi, per);
            chk("periodic high", hi, ph[i]);
            chk("periodic period", per, 2 * ph[i]);
        end
        // pwm modes: frequency and duty
        wr(A_CTRL, 32'h0000001A);
        for (int i = 0; i < 4; i++) begin
            wr(A_BOUND, {24'h000000, wb[i]});
            wr(A_SCALE, {24'h000000, ws[i]});
            meas(0, hi, per);
            meas(0, hi, per);
            chk("pwm high", hi, wh[i]);
            chk("pwm period", per, wp[i]);
        end
        // full bound gives a steady high level in both resolutions
        for (int i = 0; i < 2; i++) begin
            wr(A_SCALE, i ? 32'h00000080 : 32'h00000000);
            wr(A_BOUND, i ? 32'h0000003F : 32'h000000FF);
            repeat (300) smp();
            lows = 0;
            repeat (300) begin
                smp();
                if (timer_pin[0] !== 1'b1) lows++;
            end
            chk("pwm full duty lows", lows, 0);
        end
        // output routing to each pin, none for the spare code
        wr(A_BOUND, 32'h00000000);
        wr(A_SCALE, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            wr(A_CTRL, {24'h000000, 4'h1, sel[i], 2'h0});
            seen = 3'h0;
            repeat (16) begin
                smp();
                seen = seen | timer_pin;
            end
            chk("pin routing", {29'h00000000, seen}, {29'h00000000, pin[i]});
        end
        // wrap event: sticky status, mask, write one to clear
        wr(A_CTRL, 32'h00000000);
        wr(A_STAT, 32'h00000001);
        wr(A_BOUND, 32'h00000003);
        wr(A_CTRL, 32'h00000018);
        repeat (20) smp();
        rdc("wrap status", A_STAT, 32'h00000001);
        chk("irq masked", {31'h00000000, irq}, 32'h00000000);
        wr(A_MASK, 32'h00000001);
        repeat (2) smp();
        chk("irq unmasked", {31'h00000000, irq}, 32'h00000001);
        wr(A_CTRL, 32'h00000000);
        wr(A_STAT, 32'h00000001);
        repeat (2) smp();
        chk("irq cleared", {31'h00000000, irq}, 32'h00000000);
        rdc("status cleared", A_STAT, 32'h00000000);
        // external source: each rising edge of input 0 advances the count once
        wr(A_BOUND, 32'h00000010);
        wr(A_COUNT, 32'h00000000);
        wr(A_CTRL, 32'h00000020);
        repeat (5) begin
            @(posedge aclk);
            src_in <= 8'h03;
            repeat (2) @(posedge aclk);
            src_in <= 8'h00;
            repeat (2) @(posedge aclk);
        end
        wr(A_CTRL, 32'h00000090);
        rdc("source edge count", A_COUNT, 32'h00000005);
        // ce low freezes a wave that otherwise toggles every cycle
        wr(A_BOUND, 32'h00000000);
        wr(A_CTRL, 32'h00000018);
        ce <= 1'b0;
        smp();
        seen = timer_pin;
        lows = 0;
        repeat (8) begin
            smp();
            if (timer_pin !== seen) lows++;
        end
        @(posedge aclk);
        ce <= 1'b1;
        chk("ce freeze moves", lows, 0);
        summarize();
    end
endmodule
